// ===== port_pad_mode_config_regs.vh
`ifndef PORT_PAD_MODE_CONFIG_REGS_VH
`define PORT_PAD_MODE_CONFIG_REGS_VH

// Register addresses on the plain port
`define PORT_CFG_CTRL_ADDR        8'h00
`define PORT3_MODE_CTRL_ADDR      8'hF7
// Expanded register space bank holding port_cfg_ctrl
`define EXP_BANK_F                4'hF

// port_cfg_ctrl fields
`define PCFG_CMP_OUT_BIT          0
`define PCFG_P1_PUSHPULL_BIT      1
`define PCFG_P0_PUSHPULL_BIT      2
`define PCFG_P0_STD_BIT           3
`define PCFG_OSC_STD_BIT          7
`define PORT_CFG_CTRL_RESET       8'hFE

// port3_mode_ctrl fields
`define P3M_P2_PUSHPULL_BIT       0
`define P3M_ANALOG_BIT            1
`define PORT3_MODE_CTRL_RESET     8'h00

// Value returned by reads of write-only registers
`define WO_READ_VALUE             8'hFF

`endif

// ===== port_pad_mode_config.v
// Contract
// [RQ1] port3_mode_ctrl bit 0: 0 gives Port 2 open-drain, 1 gives push-pull.
// [RQ2] port3_mode_ctrl bit 1: 0 digital; analog masks comparator pins as stop wake sources.
// [RQ3] Both comparators disabled while in STOP mode.
// [RQ4] Analog selection survives a stop-recovery reset.
// [RQ5] port_cfg_ctrl is write-only at index 00H, bank F.
// [RQ6] port_cfg_ctrl bit 0 routes comparator outputs onto cmp_out_a/b pins.
// [RQ7] port_cfg_ctrl bit 1: Port 1 open-drain at 0, push-pull at 1, default 1.
// [RQ8] port_cfg_ctrl bit 2: Port 0 open-drain at 0, push-pull at 1, default 1.
// [RQ9] Bits 3..6 give Ports 0..3 low-emission drive at 0, default 1.
// [RQ10] Bit 7 oscillator standard drive at 1, ignored in divide-by-two crystal mode.
// [RQ11] Output bit holding 1 in open-drain mode is high impedance.
// [RQ12] Input-configured bit has its output enable deasserted.
// [RQ13] Floating input held at last valid level by a keeper.
// [RQ14] Full reset loads both registers with their default values.
`timescale 1ns/1ps
`include "port_pad_mode_config_regs.vh"

module port_pad_mode_config (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        stopRecoveryRst,
    input  wire        stopMode,
    input  wire        xtalDiv2Mode,
    input  wire [7:0]  regAddr,
    input  wire [3:0]  regBank,
    input  wire [7:0]  regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [7:0]  regRdata,
    input  wire [31:0] portOut,
    input  wire [31:0] portDirOut,
    input  wire [31:0] padIn,
    input  wire        cmpOutA,
    input  wire        cmpOutB,
    output reg  [31:0] padOut,
    output reg  [31:0] padOe,
    output reg  [31:0] padKeep,
    output reg  [3:0]  portLowEmi,
    output reg         oscStdDrive,
    output reg         cmpEnable,
    output reg  [2:0]  stopWakeMask,
    output reg         port3Analog
);

    reg [7:0]  portCfgCtrl_reg;
    reg [7:0]  port3ModeCtrl_reg;
    reg [31:0] padInMeta_reg;
    reg [31:0] padInSync_reg;
    reg        cmpAMeta_reg;
    reg        cmpASync_reg;
    reg        cmpBMeta_reg;
    reg        cmpBSync_reg;
    reg [31:0] padOut_next;
    reg [31:0] padOe_next;
    reg [31:0] keep_next;
    wire [3:0] pushPull;
    wire       cfgHit;
    wire       p3Hit;

    function portPushPull;
        input [1:0] portNum;
        input [7:0] cfg;
        input [7:0] p3m;
        begin
            case (portNum)
                2'd0:    portPushPull = cfg[`PCFG_P0_PUSHPULL_BIT];   // see [RQ8]
                2'd1:    portPushPull = cfg[`PCFG_P1_PUSHPULL_BIT];   // see [RQ7]
                2'd2:    portPushPull = p3m[`P3M_P2_PUSHPULL_BIT];    // see [RQ1]
                default: portPushPull = 1'b1;
            endcase
        end
    endfunction

    assign cfgHit = (regAddr == `PORT_CFG_CTRL_ADDR) && (regBank == `EXP_BANK_F); // see [RQ5]
    assign p3Hit  = (regAddr == `PORT3_MODE_CTRL_ADDR);

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : gPush
            // Genvar cannot be part-selected; a sized copy feeds the decoder
            localparam [1:0] PORT_NUM = p;
            assign pushPull[p] = portPushPull(PORT_NUM, portCfgCtrl_reg, port3ModeCtrl_reg);
        end
    endgenerate

    // Registers; stop-recovery reset spares the analog selection
    always @(posedge core_clk) begin
        if (srst) begin
            portCfgCtrl_reg   <= `PORT_CFG_CTRL_RESET;     // see [RQ14]
            port3ModeCtrl_reg <= `PORT3_MODE_CTRL_RESET;   // see [RQ14]
        end else if (stopRecoveryRst) begin
            portCfgCtrl_reg   <= `PORT_CFG_CTRL_RESET;
            port3ModeCtrl_reg <= `PORT3_MODE_CTRL_RESET
                                 | (port3ModeCtrl_reg & (8'h01 << `P3M_ANALOG_BIT)); // see [RQ4]
        end else if (regWr) begin
            if (cfgHit)
                portCfgCtrl_reg <= regWdata;
            if (p3Hit)
                port3ModeCtrl_reg <= regWdata;
        end
    end

    // Write-only: reads return a fixed value, no state is exposed
    always @(posedge core_clk) begin
        if (srst)
            regRdata <= 8'h00;
        else if (regRd)
            regRdata <= `WO_READ_VALUE;   // see [RQ5]
        else
            regRdata <= 8'h00;
    end

    // Pad and comparator inputs come from outside, two flops first
    always @(posedge core_clk) begin
        if (srst) begin
            padInMeta_reg <= 32'h00000000;
            padInSync_reg <= 32'h00000000;
            cmpAMeta_reg  <= 1'b0;
            cmpASync_reg  <= 1'b0;
            cmpBMeta_reg  <= 1'b0;
            cmpBSync_reg  <= 1'b0;
        end else begin
            padInMeta_reg <= padIn;
            padInSync_reg <= padInMeta_reg;
            cmpAMeta_reg  <= cmpOutA;
            cmpASync_reg  <= cmpAMeta_reg;
            cmpBMeta_reg  <= cmpOutB;
            cmpBSync_reg  <= cmpBMeta_reg;
        end
    end

    integer i;
    always @* begin
        padOut_next = portOut;
        padOe_next  = 32'h00000000;
        keep_next   = 32'h00000000;
        for (i = 0; i < 32; i = i + 1) begin
            if (portDirOut[i]) begin
                // Open-drain with a 1 leaves both transistors off
                padOe_next[i] = pushPull[i / 8] | ~portOut[i];   // see [RQ11]
            end else begin
                padOe_next[i] = 1'b0;                            // see [RQ12]
            end
            // Keeper follows last sampled level whenever undriven
            keep_next[i] = padOe_next[i] ? portOut[i] : padInSync_reg[i]; // see [RQ13]
        end
        // Stored port bits untouched; only the pin view is swapped
        if (portCfgCtrl_reg[`PCFG_CMP_OUT_BIT]) begin
            padOut_next[28] = cmpASync_reg;   // see [RQ6]
            padOut_next[31] = cmpBSync_reg;   // see [RQ6]
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            padOut       <= 32'h00000000;
            padOe        <= 32'h00000000;
            padKeep      <= 32'h00000000;
            portLowEmi   <= 4'h0;
            oscStdDrive  <= 1'b1;
            cmpEnable    <= 1'b0;
            stopWakeMask <= 3'b000;
            port3Analog  <= 1'b0;
        end else begin
            padOut      <= padOut_next;
            padOe       <= padOe_next;
            padKeep     <= keep_next;
            portLowEmi  <= ~portCfgCtrl_reg[6:`PCFG_P0_STD_BIT];                // see [RQ9]
            // Divide-by-two crystal mode ignores the low-noise request
            oscStdDrive <= portCfgCtrl_reg[`PCFG_OSC_STD_BIT] | xtalDiv2Mode;   // see [RQ10]
            port3Analog <= port3ModeCtrl_reg[`P3M_ANALOG_BIT];
            cmpEnable   <= port3ModeCtrl_reg[`P3M_ANALOG_BIT] & ~stopMode;      // see [RQ3]
            stopWakeMask <= {3{port3ModeCtrl_reg[`P3M_ANALOG_BIT]}};            // see [RQ2]
        end
    end

endmodule

// ===== pad_far_side.sv
`timescale 1ns/1ps
module pad_far_side (
    input  wire [31:0] padOut,
    input  wire [31:0] padOe,
    input  wire [31:0] extVal,
    output wire [31:0] padIn
);
    // Released pins follow the outside source, not the last driven value
    assign padIn = (padOe & padOut) | (~padOe & extVal);
endmodule

// ===== port_pad_mode_config_chk.sv
`timescale 1ns/1ps
module port_pad_mode_config_chk (
    input wire        core_clk, srst, stopRecoveryRst, stopMode, xtalDiv2Mode, regRd,
    input wire [31:0] portDirOut, padOut, padOe, padKeep,
    input wire [7:0]  regRdata,
    input wire [3:0]  portLowEmi,
    input wire [2:0]  stopWakeMask,
    input wire        oscStdDrive, cmpEnable, port3Analog
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    rd_data_a: assert property (regRd |=> regRdata == 8'hFF)
        else $error("read data not all ones");
    rd_idle_a: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data outside read cycle");
    cmp_stop_a: assert property (stopMode |=> !cmpEnable)
        else $error("comparator on in stop");
    cmp_mode_a: assert property (cmpEnable |-> port3Analog)
        else $error("comparator on in digital mode");
    wake_mask_a: assert property (stopWakeMask == {3{port3Analog}})
        else $error("wake mask wrong");
    osc_div2_a: assert property (xtalDiv2Mode |=> oscStdDrive)
        else $error("oscillator drive changed in div2");
    in_undriven_a: assert property ((padOe & ~$past(portDirOut)) == 32'h0)
        else $error("input bit driven");
    keep_drv_a: assert property (((padKeep ^ padOut) & padOe & 32'h6FFFFFFF) == 32'h0)
        else $error("keeper differs from driven level");
    rst_def_a: assert property (disable iff (1'b0) srst |=> oscStdDrive && portLowEmi == 4'h0)
        else $error("reset defaults wrong");
    smr_keep_a: assert property (port3Analog && stopRecoveryRst |=> port3Analog)
        else $error("analog mode lost");
    cover property (regRd);
    cover property (stopRecoveryRst && port3Analog);
    cover property (stopMode && port3Analog);
endmodule
bind port_pad_mode_config port_pad_mode_config_chk chk (.*);

// ===== port_pad_mode_config_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module port_pad_mode_config_bench;
    reg         core_clk = 0, srst = 1, stopRecoveryRst = 0, stopMode = 0, xtalDiv2Mode = 0;
    reg         regWr = 0, regRd = 0, cmpOutA = 0, cmpOutB = 0;
    reg  [7:0]  regAddr = 0, regWdata = 0;
    reg  [3:0]  regBank = 0;
    reg  [31:0] portOut = 32'hFFFFFFFF, portDirOut = 32'hFFFFFFFF, extVal = 0;
    wire [31:0] padIn, padOut, padOe, padKeep;
    wire [7:0]  regRdata;
    wire [3:0]  portLowEmi;
    wire [2:0]  stopWakeMask;
    wire        oscStdDrive, cmpEnable, port3Analog;
    int         n_fail = 0, check_count = 0;
    port_pad_mode_config dut (.*);
    pad_far_side far (.*);
    initial forever #12.5 core_clk = ~core_clk;
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wr(input [7:0] a, input [3:0] b, input [7:0] d);
        @(posedge core_clk);
        {regWr, regAddr, regBank, regWdata} <= {1'b1, a, b, d};
        @(posedge core_clk);
        regWr <= 0;
        step(2);
    endtask
    task t_cfg;
        wr(8'h00, 4'hF, 8'h00);
        `CHK(padOe, 32'hFF000000)
        `CHK(portLowEmi, 4'hF)
        `CHK(oscStdDrive, 1'b0)
        @(posedge core_clk);
        xtalDiv2Mode <= 1;
        step(2);
        `CHK(oscStdDrive, 1'b1)
        wr(8'h00, 4'h0, 8'hFE);
        `CHK(padOe, 32'hFF000000)
        wr(8'hF7, 4'h0, 8'h01);
        `CHK(padOe, 32'hFFFF0000)
        @(posedge core_clk);
        regRd <= 1;
        @(posedge core_clk);
        regRd <= 0;
        #1 `CHK(regRdata, 8'hFF)
        $display("config test done");
    endtask
    task t_cmp;
        @(posedge core_clk);
        {portOut, cmpOutA} <= {32'hEFFFFFFF, 1'b1};
        wr(8'h00, 4'hF, 8'h01);
        step(2);
        `CHK(padOut[31:28], 4'h7)
        wr(8'h00, 4'hF, 8'h00);
        `CHK(padOut[31:28], 4'hE)
        @(posedge core_clk);
        {portDirOut, extVal} <= {32'h00FFFFFF, 32'hA5000000};
        step(4);
        `CHK(padOe[31:24], 8'h00)
        `CHK(padKeep[31:24], 8'hA5)
        $display("pin test done");
    endtask
    task t_analog;
        wr(8'hF7, 4'h0, 8'h02);
        `CHK({port3Analog, stopWakeMask, cmpEnable}, 5'h1F)
        @(posedge core_clk);
        stopMode <= 1;
        step(2);
        `CHK(cmpEnable, 1'b0)
        @(posedge core_clk);
        stopRecoveryRst <= 1;
        @(posedge core_clk);
        stopRecoveryRst <= 0;
        step(2);
        `CHK(port3Analog, 1'b1)
        @(posedge core_clk);
        srst <= 1;
        @(posedge core_clk);
        srst <= 0;
        step(2);
        `CHK({port3Analog, oscStdDrive}, 2'h1)
        $display("analog test done");
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 0;
        step(2);
        `CHK(padOe, 32'hFF00FFFF)
        t_cfg;
        t_cmp;
        t_analog;
        print_verdict;
    end
endmodule
